// ---- common/ssa_consts.vh ----
// Constants for the shift/subtract execution datapath
`ifndef SSA_CONSTS_VH
`define SSA_CONSTS_VH
`define SSA_WORD_W      32
`define SSA_WIDE_W      33
`define SSA_SIGN_BIT    31
`define SSA_CARRY_BIT   32
`define SSA_CNT_W       5
`define SSA_REG_W       5
`define SSA_OP_W        3
`define SSA_OP_SRA_IMM  3'h0
`define SSA_OP_SRA_VAR  3'h1
`define SSA_OP_SRL_IMM  3'h2
`define SSA_OP_SRL_VAR  3'h3
`define SSA_OP_SUB_TRAP 3'h4
`define SSA_OP_SUB_WRAP 3'h5
`define SSA_ZERO_WORD   32'h00000000
`define SSA_ZERO_REG    5'h00
`endif

// ---- hdl/ssa_alu.v ----
// Shift and subtract execution stage with one-cycle registered results
// Contract
// - Arith imm shift: second source by immediate
// - Arithmetic shifts fill with bit 31
// - Arith var shift uses register count
// - Register counts use low five bits only
// - Immediate shifts use shift amount field
// - Logic imm shift fills zeros, writes dest
// - Logic var shift zero-fills, register count
// - Subtract second source from primary source
// - Trap overflow: 33-bit bits 32 vs 31
// - Overflow: no write, raise overflow exception
// - No overflow: write low 32 bits
// - Wrapping subtract never raises exception
// - Wrapping subtract writes modulo 2^32 difference
`timescale 1ns/1ns
`default_nettype none
`include "ssa_consts.vh"
module ssa_alu (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      issueValid,
  input  wire [`SSA_OP_W-1:0]      opSel,
  input  wire [`SSA_WORD_W-1:0]    primarySrc,
  input  wire [`SSA_WORD_W-1:0]    secondSrc,
  input  wire [`SSA_CNT_W-1:0]     shiftAmountField,
  input  wire [`SSA_REG_W-1:0]     destRegField,
  output reg                       writeEn,
  output reg  [`SSA_REG_W-1:0]     writeReg,
  output reg  [`SSA_WORD_W-1:0]    writeData,
  output reg                       overflowExc,
  output reg                       illegalOp
);

  // Timing: an operation presented with issueValid high is taken at
  // the next rising edge and its result stands on the outputs for
  // exactly one cycle after that edge. Operations may follow each
  // other on every cycle; nothing inside the stage holds state between
  // them, so no stall or flush input is needed.
  //
  // Write-back: writeEn qualifies writeData and writeReg. writeReg
  // follows destRegField every cycle, so the register file must look
  // at writeEn before it uses either of them.
  //
  // Exceptions: only the trapping subtract can raise overflowExc, and
  // it then drops its write so the destination keeps its old value.
  // Shifts and the wrapping subtract never raise anything.
  //
  // Illegal codes: the two unused operation codes write nothing and
  // raise illegalOp for one cycle, so the decoder can take a reserved
  // instruction trap without this stage guessing at a result.

  // Shift forms: the four codes below the subtract codes
  function isShiftOp;
    input [`SSA_OP_W-1:0] op;
    begin
      case (op)
        `SSA_OP_SRA_IMM,
        `SSA_OP_SRA_VAR,
        `SSA_OP_SRL_IMM,
        `SSA_OP_SRL_VAR: isShiftOp = 1'b1;
        default:         isShiftOp = 1'b0;
      endcase
    end
  endfunction

  // Arithmetic forms copy the sign into the vacated bits
  function isArithOp;
    input [`SSA_OP_W-1:0] op;
    begin
      case (op)
        `SSA_OP_SRA_IMM,
        `SSA_OP_SRA_VAR: isArithOp = 1'b1;
        default:         isArithOp = 1'b0;
      endcase
    end
  endfunction

  // Register-count forms take the count from the primary source
  function isVarCountOp;
    input [`SSA_OP_W-1:0] op;
    begin
      case (op)
        `SSA_OP_SRA_VAR,
        `SSA_OP_SRL_VAR: isVarCountOp = 1'b1;
        default:         isVarCountOp = 1'b0;
      endcase
    end
  endfunction

  // Subtract forms; the trap form is told apart in the result select
  function isSubOp;
    input [`SSA_OP_W-1:0] op;
    begin
      case (op)
        `SSA_OP_SUB_TRAP,
        `SSA_OP_SUB_WRAP: isSubOp = 1'b1;
        default:          isSubOp = 1'b0;
      endcase
    end
  endfunction

  // Decode and datapath intermediates
  reg  [`SSA_CNT_W-1:0]   count;
  reg                     isArith;
  reg                     isShift;
  reg                     fillBit;
  reg  [`SSA_WIDE_W-1:0]  primaryWide;
  reg  [`SSA_WIDE_W-1:0]  secondWide;
  reg  [`SSA_WIDE_W-1:0]  diffWide;
  reg                     subOverflow;
  reg                     writeEn_next;
  reg  [`SSA_WORD_W-1:0]  writeData_next;
  reg                     overflowExc_next;
  reg                     illegalOp_next;
  wire [`SSA_WORD_W-1:0]  shiftWord;
  wire [`SSA_WORD_W-1:0]  stageWord [0:`SSA_CNT_W];
  genvar                  stage;

  // Count source: the immediate field, or the low count bits of the
  // primary source; higher source bits never reach the shifter
  always @* begin
    isShift = isShiftOp(opSel);
    isArith = isArithOp(opSel);
    if (isVarCountOp(opSel)) begin
      count = primarySrc[`SSA_CNT_W-1:0];
    end else begin
      count = shiftAmountField;
    end
  end

  // Fill bit for vacated positions: sign for arithmetic, zero for logical
  always @* begin
    fillBit = isArith & secondSrc[`SSA_SIGN_BIT];
  end

  // Log shifter: stage k moves the word by 2**k when count bit k is set.
  // Five fixed stages keep the depth flat whatever the count; a zero
  // count passes every stage straight through.
  assign stageWord[0] = secondSrc;
  generate
    for (stage = 0; stage < `SSA_CNT_W; stage = stage + 1) begin : g_shift_stage
      assign stageWord[stage + 1] = count[stage] ?
        {{(1 << stage){fillBit}}, stageWord[stage][`SSA_WORD_W-1:(1 << stage)]} :
        stageWord[stage];
    end
  endgenerate
  assign shiftWord = stageWord[`SSA_CNT_W];

  // Sign-extend both operands by one bit so that bit 32 of the
  // difference disagrees with bit 31 exactly when the result overflows
  always @* begin
    primaryWide = {primarySrc[`SSA_SIGN_BIT], primarySrc};
    secondWide  = {secondSrc[`SSA_SIGN_BIT], secondSrc};
    diffWide    = primaryWide - secondWide;
    subOverflow = diffWide[`SSA_CARRY_BIT] ^ diffWide[`SSA_SIGN_BIT];
  end

  // Result select. The trap form suppresses its write on overflow so the
  // destination keeps its old value; the wrap form ignores overflow.
  // Unknown codes write nothing and flag the decoder instead.
  always @* begin
    writeEn_next     = 1'b0;
    writeData_next   = `SSA_ZERO_WORD;
    overflowExc_next = 1'b0;
    illegalOp_next   = 1'b0;
    if (issueValid) begin
      if (isShift) begin
        writeEn_next   = 1'b1;
        writeData_next = shiftWord;
      end else if (isSubOp(opSel)) begin
        if (opSel == `SSA_OP_SUB_TRAP) begin
          writeEn_next     = ~subOverflow;
          overflowExc_next = subOverflow;
          writeData_next   = subOverflow ? `SSA_ZERO_WORD : diffWide[`SSA_WORD_W-1:0];
        end else begin
          writeEn_next   = 1'b1;
          writeData_next = diffWide[`SSA_WORD_W-1:0];
        end
      end else begin
        illegalOp_next = 1'b1;
      end
    end
  end

  // Output flops. Every output comes straight from a register so the
  // write-back path sees clean timing; the price is one cycle of
  // latency, which the issue logic must allow for when it forwards a
  // result to the next operation. Data is zeroed when nothing is
  // written so a stale value never looks like a result.

  // Control flags: one-cycle pulses, cleared during reset
  always @(posedge clk) begin
    if (rst) begin
      writeEn     <= 1'b0;
      overflowExc <= 1'b0;
      illegalOp   <= 1'b0;
    end else begin
      writeEn     <= writeEn_next;
      overflowExc <= overflowExc_next;
      illegalOp   <= illegalOp_next;
    end
  end

  // Write-back address and data; the address follows every cycle
  always @(posedge clk) begin
    if (rst) begin
      writeReg  <= `SSA_ZERO_REG;
      writeData <= `SSA_ZERO_WORD;
    end else begin
      writeReg  <= destRegField;
      writeData <= writeData_next;
    end
  end

  // Limitation: no operand forwarding lives here; back-to-back
  // dependent operations rely on the register file or on a bypass
  // outside this stage.

endmodule // ssa_alu
`default_nettype wire

// ---- tb/ssa_alu_checker.sv ----
// Port checks for the shift/subtract stage
`timescale 1ns/1ns
`default_nettype none
module ssa_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        issueValid,
  input wire logic [2:0]  opSel,
  input wire logic [31:0] primarySrc,
  input wire logic [31:0] secondSrc,
  input wire logic [4:0]  shiftAmountField,
  input wire logic        writeEn,
  input wire logic [31:0] writeData,
  input wire logic        overflowExc,
  input wire logic        illegalOp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Reference results; the arithmetic shift stays apart to keep it signed
  wire [31:0] d = primarySrc - secondSrc;
  wire ov = (primarySrc[31] ^ secondSrc[31]) & (d[31] ^ primarySrc[31]);
  wire [4:0] n = opSel[0] ? primarySrc[4:0] : shiftAmountField;
  wire [31:0] asr = $signed(secondSrc) >>> n;
  wire [31:0] sh = opSel[1] ? secondSrc >> n : asr;
  sequence trapSub; issueValid && opSel == 3'h4; endsequence
  sequence wrapSub; issueValid && opSel == 3'h5; endsequence
  sequence shiftOp; issueValid && opSel < 3'h4; endsequence
  trap_flag_a: assert property (trapSub |=> overflowExc == $past(ov)) else $error("trap flag");
  ovf_nowrite_a: assert property (overflowExc |-> !writeEn) else $error("ovf write");
  trap_write_a: assert property (trapSub ##0 !ov |=> writeEn && writeData == $past(d)) else $error("trap");
  wrap_quiet_a: assert property (wrapSub |=> !overflowExc) else $error("wrap flag");
  wrap_diff_a: assert property (wrapSub |=> writeEn && writeData == $past(d)) else $error("wrap");
  shift_quiet_a: assert property (shiftOp |=> writeEn && !overflowExc) else $error("shift flag");
  shift_data_a: assert property (shiftOp |=> writeData == $past(sh)) else $error("shift");
  idle_quiet_a: assert property (!issueValid |=> !writeEn && !overflowExc) else $error("idle");
  illegal_flag_a: assert property (issueValid && opSel > 3'h5 |=> illegalOp && !writeEn) else $error("illegal");
endmodule // ssa_chk
`default_nettype wire

// ---- tb/ssa_rf.sv ----
// Register file model taking the stage's write-back
`timescale 1ns/1ns
`default_nettype none
module ssa_rf (
  input wire logic        clk,
  input wire logic        writeEn,
  input wire logic [4:0]  writeReg,
  input wire logic [31:0] writeData
);
  logic [31:0] mem [32];
  always @(posedge clk) if (writeEn) mem[writeReg] <= writeData;
endmodule // ssa_rf
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the shift/subtract stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(s,e,g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("mismatch %s %h %h", s, e, g); end end
module tb;
  logic clk = 0, rst = 1, issueValid = 0, writeEn, overflowExc, illegalOp;
  logic [2:0] opSel = 0;
  logic [31:0] primarySrc = 0, secondSrc = 0, writeData;
  logic [4:0] shiftAmountField = 0, destRegField = 3, writeReg;
  int errors = 0, n_tests = 0;
  ssa_alu dut_u (.*);
  ssa_rf rf_u (.*);
  // One operation, held for one edge; results are settled on return
  task op(input logic [2:0] o, input logic [31:0] a, b, input logic [4:0] s);
    @(posedge clk) #1 {issueValid, opSel, primarySrc, secondSrc, shiftAmountField} = {1'b1, o, a, b, s};
    @(posedge clk) #1 issueValid = 0;
  endtask
  // All shifts, zero to large counts; junk above the low five count bits
  task t_shift;
    for (int o = 0; o < 4; o++) for (int n = 0; n < 32; n += 15) begin
      op(o[2:0], {27'h7ffffff, o[0] ? n[4:0] : ~n[4:0]}, 32'h800000f0, o[0] ? ~n[4:0] : n[4:0]);
      `CHK("shift", o[1] ? 32'h800000f0 >> n : ~(32'h7fffff0f >> n), writeData)
      `CHK("flags", 3'b100, {writeEn, overflowExc, illegalOp})
    end
  endtask
  // Wrap, then an overflowing trap that must leave the register alone
  task t_sub;
    op(3'h5, 32'h80000000, 32'h1, 5'h0);
    `CHK("wrap", {2'b10, 32'h7fffffff}, {writeEn, overflowExc, writeData})
    op(3'h4, 32'h80000000, 32'h1, 5'h0);
    `CHK("ovf", 2'b01, {writeEn, overflowExc})
    op(3'h4, 32'h5, 32'h7, 5'h0);
    `CHK("keep", 32'h7fffffff, rf_u.mem[3])
    `CHK("trap", {2'b10, 32'hfffffffe}, {writeEn, overflowExc, writeData})
  endtask
  // Illegal code, then a wrap into another register
  task t_misc;
    @(posedge clk) #1 destRegField = 5'h09;
    op(3'h6, 32'h9, 32'h4, 5'h0);
    `CHK("illegal", 3'b001, {writeEn, overflowExc, illegalOp})
    op(3'h5, 32'h9, 32'h4, 5'h0);
    `CHK("dest", {1'b1, 5'h09, 32'h5}, {writeEn, writeReg, writeData})
    @(posedge clk) #1;
    `CHK("rf", 32'h5, rf_u.mem[9])
  endtask
  task give_verdict;
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    t_shift;
    t_sub;
    t_misc;
    give_verdict;
  end
  // About 60 cycles of work; far beyond that means a hang
  initial begin
    #4000 errors++;
    give_verdict;
  end
endmodule // tb
bind ssa_alu ssa_chk chk_u (.*);
`default_nettype wire
